/* File: design/bcd_parallel_remote_control.sv */
// Summary of operation
// RULE1: While remote mode is on, bus traffic is blocked; settings come from lines.
// RULE2: Remote mode is kept, also across power cycles, until released.
// RULE3: Release by select line going high restores prior display and output.
// RULE4: Limiter indicator asserts when limiter engages in operate.
// RULE5: Output-active indicator shows operate versus standby.
// RULE6: Both indicators stay driven outside remote mode.
// RULE7: Local key cycles normal, address, setup; enter in setup starts remote.
// RULE8: All lines high decode to zero output on the 1 V range.
// RULE9: Local key cancels remote mode and returns to local control.
// RULE10: Controller presents seven BCD digits, lowest decade first, four lines each.
// RULE11: Lines select voltage or current, divider ranges, and divider on/off.
// RULE12: Lines carry polarity, limit levels and operate/standby, decoded in remote.
// RULE13: All remote lines are inverted: low is one, high is zero.
// RULE14: Range field 00, 01, 10 are decades; 11 is the 1000 V range.
// RULE15: Inputs are synchronised and accepted only after several stable samples.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/100ps

module bcd_parallel_remote_control (
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic [remote_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [31:0]                   reg_rdata,
  input  wire remote_pkg::lines_t            remote_lines_n,
  input  wire logic                          key_local,
  input  wire logic                          key_enter,
  input  wire remote_pkg::setting_t          local_setting,
  input  wire logic                          limiter_engaged,
  input  wire logic                          backup_remote,
  output logic                               backup_store,
  output remote_pkg::setting_t               active_setting,
  output logic                               restore_strobe,
  output logic                               gpib_block,
  output logic                               remote_lamp,
  output remote_pkg::menu_t                  menu_show,
  output logic                               limit_flag_n,
  output logic                               output_active_indicator_n,
  output logic                               irq
);

  // ==========================================================================
  // Sample divider and line filter
  // ==========================================================================
  logic [remote_pkg::SAMPLE_CNT_W-1:0] div_cnt;
  logic [remote_pkg::SAMPLE_CNT_W-1:0] next_div_cnt;
  logic                                sample_en;
  logic                                next_sample_en;
  logic [remote_pkg::FILTER_W-1:0]     filter_need;
  remote_pkg::lines_t                  lines_f;

  always_comb begin
    next_sample_en = (div_cnt == remote_pkg::SAMPLE_CNT_W'(remote_pkg::SAMPLE_CYCLES - 1));
    next_div_cnt   = next_sample_en ? '0 : div_cnt + 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt   <= '0;
      sample_en <= 1'b0;
    end else begin
      div_cnt   <= next_div_cnt;
      sample_en <= next_sample_en;
    end
  end

  line_filter u_filter (
    .core_clk    (core_clk),
    .rstn        (rstn),
    .raw         (remote_lines_n),
    .sample_en   (sample_en),
    .stable_need (filter_need),
    .filtered    (lines_f)
  ); // RULE15

  // Inverted logic: low line is a logical one
  remote_pkg::setting_t decoded;
  logic                 select_on;

  always_comb begin
    decoded   = ~lines_f.setting; // RULE13 RULE8 RULE10 RULE11 RULE12 RULE14
    select_on = ~lines_f.select;  // RULE13
  end

  // ==========================================================================
  // Retained mode
  // ==========================================================================
  logic start_remote;
  logic remote_on;

  mode_retain u_retain (
    .core_clk      (core_clk),
    .rstn          (rstn),
    .backup_remote (backup_remote),
    .remote_on     (remote_on),
    .start_remote  (start_remote),
    .backup_store  (backup_store)
  ); // RULE2

  // ==========================================================================
  // Mode and menu state machine
  // ==========================================================================
  remote_pkg::menu_t    menu;
  remote_pkg::menu_t    next_menu;
  remote_pkg::setting_t snapshot;
  remote_pkg::setting_t next_snapshot;
  logic                 next_remote_on;
  logic                 select_seen;
  logic                 next_select_seen;
  logic                 enter_evt;
  logic                 release_evt;

  always_comb begin
    next_menu        = menu;
    next_remote_on   = remote_on;
    next_snapshot    = snapshot;
    next_select_seen = select_seen;
    enter_evt        = 1'b0;
    release_evt      = 1'b0;
    if (remote_on) begin
      if (select_on) begin
        next_select_seen = 1'b1;
      end
      if (key_local) begin
        next_remote_on = 1'b0; // RULE9
        next_menu      = remote_pkg::MENU_NORMAL;
        release_evt    = 1'b1;
      end else if (select_seen && !select_on) begin
        next_remote_on = 1'b0; // RULE3
        release_evt    = 1'b1;
      end
    end else if (start_remote) begin
      next_remote_on   = 1'b1; // RULE2
      next_snapshot    = local_setting;
      next_select_seen = 1'b0;
      enter_evt        = 1'b1;
    end else if (key_local) begin
      case (menu) // RULE7
        remote_pkg::MENU_NORMAL: next_menu = remote_pkg::MENU_ADDR;
        remote_pkg::MENU_ADDR:   next_menu = remote_pkg::MENU_BCD;
        default:                 next_menu = remote_pkg::MENU_NORMAL;
      endcase
    end else if (key_enter && menu == remote_pkg::MENU_BCD) begin
      next_remote_on   = 1'b1; // RULE7
      next_menu        = remote_pkg::MENU_NORMAL;
      next_snapshot    = local_setting;
      next_select_seen = 1'b0;
      enter_evt        = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      menu        <= remote_pkg::MENU_NORMAL;
      remote_on   <= 1'b0;
      snapshot    <= '0;
      select_seen <= 1'b0;
    end else begin
      menu        <= next_menu;
      remote_on   <= next_remote_on;
      snapshot    <= next_snapshot;
      select_seen <= next_select_seen;
    end
  end

  // ==========================================================================
  // Outputs and indicators
  // ==========================================================================
  remote_pkg::setting_t next_active;
  logic                 operating;
  logic                 next_limit_flag_n;
  logic                 next_op_flag_n;

  always_comb begin
    if (next_remote_on) begin
      next_active = decoded; // RULE1
    end else if (release_evt) begin
      next_active = snapshot; // RULE3
    end else begin
      next_active = local_setting;
    end
    operating         = active_setting.operate;
    next_limit_flag_n = ~(limiter_engaged && operating); // RULE4 RULE6
    next_op_flag_n    = ~operating;                      // RULE5 RULE6
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      active_setting            <= '0;
      restore_strobe            <= 1'b0;
      gpib_block                <= 1'b0;
      remote_lamp               <= 1'b0;
      limit_flag_n              <= 1'b1;
      output_active_indicator_n <= 1'b1;
    end else begin
      active_setting            <= next_active;
      restore_strobe            <= release_evt;
      gpib_block                <= next_remote_on; // RULE1
      remote_lamp               <= next_remote_on; // RULE7
      limit_flag_n              <= next_limit_flag_n;
      output_active_indicator_n <= next_op_flag_n;
    end
  end

  always_comb begin
    menu_show = menu;
  end

  // ==========================================================================
  // Registers, events and interrupt
  // ==========================================================================
  logic [remote_pkg::EV_W-1:0]     status;
  logic [remote_pkg::EV_W-1:0]     mask;
  logic [remote_pkg::EV_W-1:0]     events;
  logic [remote_pkg::EV_W-1:0]     next_status;
  logic [remote_pkg::EV_W-1:0]     next_mask;
  logic [remote_pkg::FILTER_W-1:0] next_filter_need;
  logic [31:0]                     next_rdata;
  logic                            limit_prev;
  logic                            next_irq;
  remote_pkg::setting_t            decoded_prev;

  always_comb begin
    events                         = '0;
    events[remote_pkg::EV_ENTER]   = enter_evt;
    events[remote_pkg::EV_RELEASE] = release_evt;
    events[remote_pkg::EV_LIMIT]   = !limit_flag_n && !limit_prev;
    events[remote_pkg::EV_CHANGE]  = remote_on && (decoded != decoded_prev);
    next_status      = status;
    next_mask        = mask;
    next_filter_need = filter_need;
    if (reg_wr) begin
      if (reg_addr == remote_pkg::OFS_STATUS) begin
        next_status = status & ~reg_wdata[remote_pkg::EV_W-1:0];
      end else if (reg_addr == remote_pkg::OFS_MASK) begin
        next_mask = reg_wdata[remote_pkg::EV_W-1:0];
      end else if (reg_addr == remote_pkg::OFS_FILTER) begin
        next_filter_need = reg_wdata[remote_pkg::FILTER_W-1:0];
      end
    end
    // Set wins over a clear in the same cycle
    next_status = next_status | events;
    next_irq    = |(next_status & next_mask);
    next_rdata  = '0;
    if (reg_rd) begin
      if (reg_addr == remote_pkg::OFS_STATUS) begin
        next_rdata[remote_pkg::EV_W-1:0] = status;
      end else if (reg_addr == remote_pkg::OFS_MASK) begin
        next_rdata[remote_pkg::EV_W-1:0] = mask;
      end else if (reg_addr == remote_pkg::OFS_MODE) begin
        next_rdata[remote_pkg::MODE_REMOTE]      = remote_on;
        next_rdata[remote_pkg::MODE_BLOCK]       = gpib_block;
        next_rdata[remote_pkg::MODE_MENU +: 2]   = menu;
        next_rdata[remote_pkg::MODE_OPERATE]     = operating;
      end else if (reg_addr == remote_pkg::OFS_FILTER) begin
        next_rdata[remote_pkg::FILTER_W-1:0] = filter_need;
      end else if (reg_addr == remote_pkg::OFS_VALUE) begin
        next_rdata[remote_pkg::VALUE_W-1:0] = active_setting.value;
      end else if (reg_addr == remote_pkg::OFS_CONTROLS) begin
        next_rdata[remote_pkg::SETTING_W-remote_pkg::VALUE_W-1:0] =
          active_setting[remote_pkg::SETTING_W-remote_pkg::VALUE_W-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status       <= '0;
      mask         <= remote_pkg::MASK_RESET;
      filter_need  <= remote_pkg::FILTER_RESET;
      reg_rdata    <= '0;
      irq          <= 1'b0;
      limit_prev   <= 1'b0;
      decoded_prev <= '0;
    end else begin
      status       <= next_status;
      mask         <= next_mask;
      filter_need  <= next_filter_need;
      reg_rdata    <= next_rdata;
      irq          <= next_irq;
      limit_prev   <= !limit_flag_n;
      decoded_prev <= decoded;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_enter_bcd;
    !remote_on && !start_remote && !key_local && key_enter && menu == remote_pkg::MENU_BCD;
  endsequence

  sequence s_remote_up;
    remote_on && remote_lamp && gpib_block;
  endsequence

  property p_block;
    remote_on |-> gpib_block && active_setting == $past(decoded);
  endproperty
  a_block: assert property (p_block) else $error("bus not blocked in remote"); // RULE1

  property p_retain;
    remote_on && !key_local && !(select_seen && !select_on) |=> remote_on;
  endproperty
  a_retain: assert property (p_retain) else $error("remote mode dropped"); // RULE2

  property p_restore;
    remote_on && !key_local && select_seen && !select_on
      |=> !remote_on && restore_strobe && active_setting == $past(snapshot);
  endproperty
  a_restore: assert property (p_restore) else $error("settings not restored"); // RULE3

  property p_limit;
    limiter_engaged && active_setting.operate |=> !limit_flag_n;
  endproperty
  a_limit: assert property (p_limit) else $error("limit flag missing"); // RULE4

  property p_opflag;
    ##1 output_active_indicator_n == !$past(active_setting.operate);
  endproperty
  a_opflag: assert property (p_opflag) else $error("output flag wrong"); // RULE5

  property p_local_flags;
    !remote_on && !active_setting.operate |=> output_active_indicator_n && limit_flag_n;
  endproperty
  a_local_flags: assert property (p_local_flags) else $error("flags not driven"); // RULE6

  property p_menu;
    !remote_on && !start_remote && key_local && menu == remote_pkg::MENU_ADDR
      |=> menu == remote_pkg::MENU_BCD;
  endproperty
  a_menu: assert property (p_menu) else $error("menu did not step"); // RULE7

  property p_enter;
    s_enter_bcd |=> s_remote_up;
  endproperty
  a_enter: assert property (p_enter) else $error("remote not entered"); // RULE7

  property p_zero;
    next_remote_on && lines_f.setting == '1 |=> active_setting == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("idle lines not zero"); // RULE8

  property p_cancel;
    remote_on && key_local |=> !remote_on && !remote_lamp ##1 !backup_store;
  endproperty
  a_cancel: assert property (p_cancel) else $error("local key ignored"); // RULE9

  property p_filter;
    $changed(lines_f) |-> $past(sample_en);
  endproperty
  a_filter: assert property (p_filter) else $error("unfiltered change"); // RULE15

endmodule

/* File: design/line_filter.sv */
`timescale 1ns/100ps

module line_filter (
  input  wire logic                        core_clk,
  input  wire logic                        rstn,
  input  wire logic [remote_pkg::LINES_W-1:0] raw,
  input  wire logic                        sample_en,
  input  wire logic [remote_pkg::FILTER_W-1:0] stable_need,
  output logic      [remote_pkg::LINES_W-1:0] filtered
);

  // ==========================================================================
  // Two-stage synchroniser per line
  // ==========================================================================
  logic [remote_pkg::LINES_W-1:0] meta;
  logic [remote_pkg::LINES_W-1:0] sync;

  genvar gi;
  generate
    for (gi = 0; gi < remote_pkg::LINES_W; gi++) begin : g_sync
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          meta[gi] <= 1'b1;
          sync[gi] <= 1'b1;
        end else begin
          meta[gi] <= raw[gi];
          sync[gi] <= meta[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Stability filter: whole word must hold for stable_need + 2 samples
  // ==========================================================================
  logic [remote_pkg::LINES_W-1:0]  candidate;
  logic [remote_pkg::FILTER_W-1:0] count;
  logic [remote_pkg::LINES_W-1:0]  next_candidate;
  logic [remote_pkg::FILTER_W-1:0] next_count;
  logic [remote_pkg::LINES_W-1:0]  next_filtered;

  always_comb begin
    next_candidate = candidate;
    next_count     = count;
    next_filtered  = filtered;
    if (sample_en) begin
      if (sync != candidate) begin
        next_candidate = sync;
        next_count     = '0;
      end else if (count < stable_need) begin
        next_count = count + 1'b1;
      end else begin
        next_filtered = candidate;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      candidate <= '1;
      count     <= '0;
      filtered  <= '1;
    end else begin
      candidate <= next_candidate;
      count     <= next_count;
      filtered  <= next_filtered;
    end
  end

endmodule

/* File: design/mode_retain.sv */
`timescale 1ns/100ps

module mode_retain (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic backup_remote,
  input  wire logic remote_on,
  output logic      start_remote,
  output logic      backup_store
);

  // Backup level is caught once, on the first edge after reset release
  logic armed;
  logic next_armed;
  logic next_start_remote;

  always_comb begin
    next_armed        = 1'b1;
    next_start_remote = !armed && backup_remote;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      armed        <= 1'b0;
      start_remote <= 1'b0;
      backup_store <= 1'b0;
    end else begin
      armed        <= next_armed;
      start_remote <= next_start_remote;
      backup_store <= remote_on;
    end
  end

endmodule

/* File: design/remote_pkg.sv */
package remote_pkg;

  // ==========================================================================
  // Remote setting carried by the parallel lines (logical, after inversion)
  // ==========================================================================
  localparam int DIGITS    = 7;
  localparam int DIGIT_W   = 4;
  localparam int VALUE_W   = DIGITS * DIGIT_W;

  typedef struct packed {
    logic [VALUE_W-1:0] value;     // Digit 0 (lowest decade) in bits 3:0
    logic               current;   // 1 = current function, 0 = voltage
    logic [1:0]         range;     // 00 lowest, 01, 10, 11 = 1000 V range
    logic               negative;
    logic               divider;   // Divider path on
    logic [1:0]         vlimit;
    logic [1:0]         ilimit;
    logic               operate;   // remote_operate_request
  } setting_t;

  localparam int SETTING_W = $bits(setting_t);

  // Raw connector lines, active low; select low means remote requested
  typedef struct packed {
    logic     select;
    setting_t setting;
  } lines_t;

  localparam int LINES_W = $bits(lines_t);

  typedef enum logic [1:0] {
    MENU_NORMAL = 2'b00,
    MENU_ADDR   = 2'b01,
    MENU_BCD    = 2'b10
  } menu_t;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int         ADDR_W       = 5;
  localparam logic [4:0] OFS_STATUS   = 5'h00;
  localparam logic [4:0] OFS_MASK     = 5'h04;
  localparam logic [4:0] OFS_MODE     = 5'h08;
  localparam logic [4:0] OFS_FILTER   = 5'h0c;
  localparam logic [4:0] OFS_VALUE    = 5'h10;
  localparam logic [4:0] OFS_CONTROLS = 5'h14;

  localparam int EV_W       = 4;
  localparam int EV_ENTER   = 0;
  localparam int EV_RELEASE = 1;
  localparam int EV_LIMIT   = 2;
  localparam int EV_CHANGE  = 3;

  localparam int MODE_REMOTE  = 0;
  localparam int MODE_BLOCK   = 1;
  localparam int MODE_MENU    = 2;
  localparam int MODE_OPERATE = 4;

  localparam int              FILTER_W       = 4;
  localparam logic [3:0]      FILTER_RESET   = 4'h4;
  localparam logic [EV_W-1:0] MASK_RESET     = 4'h0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int SAMPLE_NS     = 1000;
  localparam int CLK_MHZ       = 250;
  localparam int SAMPLE_CYCLES = (SAMPLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SAMPLE_CNT_W  = $clog2(SAMPLE_CYCLES);

endpackage

/* File: verification/bcd_controller_model.sv */
`timescale 1ns/100ps

module bcd_controller_model (
  input  wire logic                 connected,
  input  wire logic                 select,
  input  wire remote_pkg::setting_t setting,
  output remote_pkg::lines_t        lines_n
);
  // ==========================================================================
  // Parallel lines, low is logical one; an unplugged cable reads all high
  // ==========================================================================
  assign lines_n = connected ? ~{select, setting} : '1;
endmodule

/* File: verification/bcd_parallel_remote_control_tb.sv */
`timescale 1ns/100ps

module bcd_parallel_remote_control_tb;
  logic                          core_clk        = 1'b0;
  logic                          rstn            = 1'b0;
  logic [remote_pkg::ADDR_W-1:0] reg_addr        = '0;
  logic [31:0]                   reg_wdata       = '0;
  logic                          reg_wr          = 1'b0;
  logic                          reg_rd          = 1'b0;
  logic                          key_local       = 1'b0;
  logic                          key_enter       = 1'b0;
  logic                          limiter_engaged = 1'b0;
  logic                          backup_remote   = 1'b0;
  logic                          connected       = 1'b0;
  logic                          select          = 1'b0;
  remote_pkg::setting_t          local_setting   = '0;
  remote_pkg::setting_t          rem_setting     = '0;
  logic [31:0]                   reg_rdata;
  remote_pkg::lines_t            remote_lines_n;
  logic                          backup_store;
  remote_pkg::setting_t          active_setting;
  logic                          restore_strobe;
  logic                          gpib_block;
  logic                          remote_lamp;
  remote_pkg::menu_t             menu_show;
  logic                          limit_flag_n;
  logic                          output_active_indicator_n;
  logic                          irq;
  int                            failures        = 0;
  int                            samples_checked = 0;
  logic [31:0]                   rd;
  remote_pkg::setting_t          loc;
  remote_pkg::setting_t          loc2;
  remote_pkg::setting_t          rem;

  always #2 core_clk = ~core_clk;

  bcd_controller_model partner (
    .connected (connected),
    .select    (select),
    .setting   (rem_setting),
    .lines_n   (remote_lines_n)
  );

  bcd_parallel_remote_control dut (
    .core_clk                  (core_clk),
    .rstn                      (rstn),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .remote_lines_n            (remote_lines_n),
    .key_local                 (key_local),
    .key_enter                 (key_enter),
    .local_setting             (local_setting),
    .limiter_engaged           (limiter_engaged),
    .backup_remote             (backup_remote),
    .backup_store              (backup_store),
    .active_setting            (active_setting),
    .restore_strobe            (restore_strobe),
    .gpib_block                (gpib_block),
    .remote_lamp               (remote_lamp),
    .menu_show                 (menu_show),
    .limit_flag_n              (limit_flag_n),
    .output_active_indicator_n (output_active_indicator_n),
    .irq                       (irq)
  );

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task print_verdict;
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task reg_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task reg_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task press(input bit enter);
    @(posedge core_clk);
    if (enter) key_enter <= 1'b1;
    else key_local <= 1'b1;
    @(posedge core_clk);
    key_enter <= 1'b0;
    key_local <= 1'b0;
    #1;
  endtask

  // Waits for the setting and the block flag together; a used-up bound ends the run
  task wait_for(input remote_pkg::setting_t exp, input bit blk);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge core_clk);
      #1;
      if (active_setting === exp && gpib_block === blk) break;
    end
    if (n == 3000) begin
      failures++;
      print_verdict();
    end
  endtask

  initial begin
    #400000;
    failures++;
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    loc = '0;
    loc.value = 28'h0001234;
    loc.operate = 1'b1;
    loc2 = '0;
    loc2.value = 28'h0000777;
    rem = '0;
    rem.value = 28'h9876543;
    rem.current = 1'b1;
    rem.range = 2'b11;
    rem.negative = 1'b1;
    rem.divider = 1'b1;
    rem.vlimit = 2'b10;
    rem.ilimit = 2'b01;
    rem.operate = 1'b1;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    reg_read(remote_pkg::OFS_MASK, rd);
    check(rd, remote_pkg::MASK_RESET);
    reg_read(remote_pkg::OFS_FILTER, rd);
    check(rd, remote_pkg::FILTER_RESET);
    check(output_active_indicator_n, 1'b1);
    $display("test reset done");
    press(1'b1);
    check(gpib_block, 1'b0);
    press(1'b0);
    check(menu_show, remote_pkg::MENU_ADDR);
    press(1'b1);
    check(gpib_block, 1'b0);
    press(1'b0);
    check(menu_show, remote_pkg::MENU_BCD);
    press(1'b0);
    check(menu_show, remote_pkg::MENU_NORMAL);
    $display("test menu done");
    @(posedge core_clk);
    local_setting <= loc;
    limiter_engaged <= 1'b1;
    reg_write(remote_pkg::OFS_MASK, 32'h1);
    @(posedge core_clk);
    #1 check(output_active_indicator_n, 1'b0);
    check(limit_flag_n, 1'b0);
    press(1'b0);
    press(1'b0);
    press(1'b1);
    check(gpib_block, 1'b1);
    check(remote_lamp, 1'b1);
    check(active_setting, 38'h0);
    @(posedge core_clk);
    local_setting <= loc2;
    @(posedge core_clk);
    #1 check(backup_store, 1'b1);
    reg_read(remote_pkg::OFS_MODE, rd);
    check(rd, 32'h3);
    check(irq, 1'b1);
    check(output_active_indicator_n, 1'b1);
    check(limit_flag_n, 1'b1);
    reg_write(remote_pkg::OFS_STATUS, 32'h1);
    @(posedge core_clk);
    #1 check(irq, 1'b0);
    reg_read(remote_pkg::OFS_STATUS, rd);
    check(rd, 32'h4);
    $display("test entry done");
    @(posedge core_clk);
    select <= 1'b1;
    rem_setting <= rem;
    connected <= 1'b1;
    wait_for(rem, 1'b1);
    check(active_setting, rem);
    reg_read(remote_pkg::OFS_VALUE, rd);
    check(rd, {4'h0, rem.value});
    reg_read(remote_pkg::OFS_CONTROLS, rd);
    check(rd, 32'h3f3);
    check(output_active_indicator_n, 1'b0);
    check(limit_flag_n, 1'b0);
    @(posedge core_clk);
    rem_setting.value <= 28'h1111111;
    repeat (300) @(posedge core_clk);
    #1 check(active_setting, rem);
    @(posedge core_clk);
    rem_setting <= rem;
    repeat (1500) @(posedge core_clk);
    #1 check(active_setting, rem);
    $display("test lines done");
    press(1'b0);
    check(restore_strobe, 1'b1);
    check(active_setting, loc);
    check(gpib_block, 1'b0);
    @(posedge core_clk);
    #1 check(active_setting, loc2);
    press(1'b0);
    press(1'b0);
    press(1'b1);
    check(active_setting, rem);
    @(posedge core_clk);
    select <= 1'b0;
    wait_for(loc2, 1'b0);
    check(remote_lamp, 1'b0);
    $display("test release done");
    @(posedge core_clk);
    backup_remote <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 check(gpib_block, 1'b1);
    $display("test retention done");
    print_verdict();
  end
endmodule
